/* File: rtl/pio_pkg.sv */
/*
  Constants and types shared by the pulse I/O terminal allocator.
  Assumes a 125 MHz clock and an 8-bit APB byte address.
*/
package pio_pkg;
  // Register byte offsets
  localparam logic [7:0] A_MOD0_IN  = 8'h00;
  localparam logic [7:0] A_MOD0_OUT = 8'h04;
  localparam logic [7:0] A_MOD1_IN  = 8'h08;
  localparam logic [7:0] A_MOD1_OUT = 8'h0c;
  localparam logic [7:0] A_INT_SEL  = 8'h10;
  localparam logic [7:0] A_QRS_SEL  = 8'h14;
  localparam logic [7:0] A_CNT_SEL  = 8'h18;
  localparam logic [7:0] A_ORG_SEL  = 8'h1c;
  localparam logic [7:0] A_TC_SEL   = 8'h20;
  localparam logic [7:0] A_INSTR    = 8'h24;
  localparam logic [7:0] A_STATUS   = 8'h28;
  // Field positions
  localparam int ZUSE_LSB    = 4;
  localparam int OMODE_LSB   = 4;
  localparam int TC_ACT_LSB  = 8;
  localparam int I_MOD_BIT   = 2;
  localparam int I_CH_BIT    = 3;
  localparam int I_METH_BIT  = 4;
  localparam int I_BIT_LSB   = 8;
  localparam int REFUSED_BIT = 20;
  // Instruction codes and operands
  localparam logic [1:0] OP_OUT   = 2'h0;
  localparam logic [1:0] OP_PULSE = 2'h1;
  localparam logic [1:0] OP_ORG   = 2'h2;
  localparam logic [1:0] OP_PWM   = 2'h3;
  localparam logic       METH_CWCCW = 1'h0;
  localparam logic [1:0] OMODE_1 = 2'h1;
  localparam logic [1:0] OMODE_2 = 2'h2;
  localparam logic [2:0] OUT_TERMS = 3'h6;
  // Input time constant: 0 none, 1..7 = 0.5,1,2,4,8,16,32 ms
  localparam logic [2:0] TC_NONE    = 3'h0;
  localparam logic [2:0] TC_DEFAULT = 3'h5;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_TIME_NS  = 500000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    BIND_NORMAL, BIND_CW, BIND_CCW, BIND_PULSE, BIND_DIR, BIND_ECR, BIND_PWM
  } pio_bind_t;

  function automatic logic [6:0] tc_ticks(input logic [2:0] code);
    tc_ticks = (code == TC_NONE) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
  endfunction

  function automatic logic ecr_mode(input logic [1:0] mode);
    ecr_mode = (mode == OMODE_1) || (mode == OMODE_2);
  endfunction
endpackage

/* File: rtl/pio_in_filter.sv */
/*
  Debounce filter for the twenty input terminals.
  Assumes inputs synchronous to clk; the selection is held stable.
*/
`timescale 1ns/1ps
module pio_in_filter #(
  parameter int TICK_CYCLES = pio_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // Terminals
  input  wire logic [19:0] raw,
  input  wire logic [2:0]  tc_code,
  output logic      [19:0] filt
);
  logic [16:0] pre;
  logic        tick;
  logic [6:0]  limit;

  assign tick  = (pre == 17'(TICK_CYCLES - 1));
  assign limit = pio_pkg::tc_ticks(tc_code);

  // One shared 0.5 ms prescaler keeps per-bit counters small
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      pre <= 17'h00000;
    else if (ce)
      pre <= tick ? 17'h00000 : pre + 17'h00001;
  end

  for (genvar i = 0; i < 20; i++) begin : g_bit
    logic [6:0] cnt;
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        cnt     <= 7'h00;
        filt[i] <= 1'h0;
      end else if (ce) begin
        if (tc_code == pio_pkg::TC_NONE || raw[i] == filt[i]) begin
          cnt     <= 7'h00;
          filt[i] <= raw[i];
        end else if (tick) begin
          if (cnt + 7'h01 >= limit) begin
            cnt     <= 7'h00;
            filt[i] <= raw[i];
          end else begin
            cnt <= cnt + 7'h01;
          end
        end
      end
    end
  end
endmodule // pio_in_filter

/* File: rtl/pio_out_bind.sv */
/*
  Output terminal binding for one module (six terminals).
  Assumes instructions arrive as single-cycle strobes.
*/
`timescale 1ns/1ps
module pio_out_bind (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // Instruction strobe
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_op,
  input  wire logic       cmd_ch,
  input  wire logic       cmd_meth,
  input  wire logic [2:0] cmd_bit,
  input  wire logic [1:0] org_mode,
  output logic            refused,
  // Function sources
  input  wire logic [5:0] norm_out,
  input  wire logic [1:0] pulse_a,
  input  wire logic [1:0] pulse_b,
  input  wire logic [1:0] ecr,
  input  wire logic [1:0] pwm,
  output logic      [5:0] term_out
);
  pio_pkg::pio_bind_t bind_q [6];
  logic [2:0] c;

  assign c = {2'h0, cmd_ch};
  assign refused = ce && cmd_valid && cmd_op == pio_pkg::OP_PWM
                   && pio_pkg::ecr_mode(org_mode);

  // Binding changes only when an instruction acts on the terminal
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 6; i++)
        bind_q[i] <= pio_pkg::BIND_NORMAL;
    end else if (ce && cmd_valid) begin
      unique case (cmd_op)
        pio_pkg::OP_OUT: begin
          if (cmd_bit < pio_pkg::OUT_TERMS)
            bind_q[cmd_bit] <= pio_pkg::BIND_NORMAL;
        end
        pio_pkg::OP_PULSE, pio_pkg::OP_ORG: begin
          if (cmd_meth == pio_pkg::METH_CWCCW) begin
            bind_q[2 * c]     <= pio_pkg::BIND_CW;
            bind_q[2 * c + 1] <= pio_pkg::BIND_CCW;
          end else begin
            bind_q[c]     <= pio_pkg::BIND_PULSE;
            bind_q[c + 2] <= pio_pkg::BIND_DIR;
          end
          if (cmd_op == pio_pkg::OP_ORG && pio_pkg::ecr_mode(org_mode))
            bind_q[c + 4] <= pio_pkg::BIND_ECR;
        end
        pio_pkg::OP_PWM: begin
          if (!pio_pkg::ecr_mode(org_mode))
            bind_q[c + 4] <= pio_pkg::BIND_PWM;
        end
      endcase
    end
  end

  for (genvar b = 0; b < 6; b++) begin : g_term
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
        term_out[b] <= 1'h0;
      else if (ce) begin
        unique case (bind_q[b])
          pio_pkg::BIND_CW:    term_out[b] <= pulse_a[b / 2 % 2];
          pio_pkg::BIND_CCW:   term_out[b] <= pulse_b[b / 2 % 2];
          pio_pkg::BIND_PULSE: term_out[b] <= pulse_a[b % 2];
          pio_pkg::BIND_DIR:   term_out[b] <= pulse_b[b % 2];
          pio_pkg::BIND_ECR:   term_out[b] <= ecr[b % 2];
          pio_pkg::BIND_PWM:   term_out[b] <= pwm[b % 2];
          default:             term_out[b] <= norm_out[b];
        endcase
      end
    end
  end
endmodule // pio_out_bind

/* File: rtl/pio_terminal_allocator.sv */
/*
  Terminal allocator for a two-module pulse I/O expansion, APB slave.
  Assumes counter, interrupt and pulse engines outside; inputs are
  synchronous to clk.
*/
`timescale 1ns/1ps
// What this block does
// - A terminal taken as quick-response input feeds no other function.
// - An output terminal gets its function when an instruction acts on it.
// - Output, origin search and PWM instructions each pick the terminal's driver.
// - In origin mode one or two the error-reset terminals refuse PWM use.
// - An instruction operand picks CW/COUNTER_CLOCKWISE_PULSE or pulse plus direction encoding.
// - Normal inputs pass a selectable filter, 8 ms by default.
// - Interrupt, quick-response and counter inputs bypass the filter.
// - A new time constant acts only at the next power-on load.
// - Origin search beats counter Z/reset, which beats the other inputs.
module pio_terminal_allocator #(
  parameter int TICK_CYCLES = pio_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        power_on_load,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Input terminals and routed functions
  input  wire logic [19:0] term_in,
  output logic      [19:0] norm_in,
  output logic      [7:0]  intr_in,
  output logic      [7:0]  qrs_in,
  output logic      [3:0]  cnt_a,
  output logic      [3:0]  cnt_b,
  output logic      [3:0]  cnt_z,
  output logic      [3:0]  org_in,
  output logic      [3:0]  org_prox,
  output logic      [3:0]  pos_done,
  // Output engines and terminals
  input  wire logic [3:0]  pulse_a,
  input  wire logic [3:0]  pulse_b,
  input  wire logic [3:0]  ecr,
  input  wire logic [3:0]  pwm,
  output logic      [11:0] term_out
);
  logic [5:0]  out0;
  logic [5:0]  out1;
  logic [7:0]  int_sel;
  logic [7:0]  qrs_sel;
  logic [7:0]  cnt_sel;
  logic [5:0]  org_sel;
  logic [2:0]  tc_pend;
  logic [2:0]  tc_act;
  logic        refused_q;
  logic [1:0]  refused;
  logic [19:0] filt;
  logic [19:0] o_c;
  logic [19:0] c_c;
  logic [19:0] i_c;
  logic [19:0] q_c;
  logic [19:0] o_g;
  logic [19:0] c_g;
  logic [19:0] i_g;
  logic [19:0] q_g;
  logic [19:0] n_g;
  logic [19:0] conflict;
  logic [19:0] eff_in;
  logic [7:0]  next_intr;
  logic [7:0]  next_qrs;
  logic [3:0]  next_cnt_a;
  logic [3:0]  next_cnt_b;
  logic [3:0]  next_cnt_z;
  logic [3:0]  next_org;
  logic [3:0]  next_prox;
  logic [3:0]  next_done;
  logic        setup;
  logic        wr;
  logic        mapped;
  logic        instr_wr;
  logic [31:0] next_prdata;

  // APB decode; always ready, so every access ends in its first
  // access cycle unless the clock enable holds it
  assign pready  = ce;
  assign setup   = psel && !penable && ce;
  assign wr      = psel && penable && pwrite && ce;
  assign pslverr = psel && penable && !mapped;
  assign instr_wr = wr && paddr == pio_pkg::A_INSTR;

  always_comb begin
    mapped = 1'h1;
    next_prdata = 32'h00000000;
    unique case (paddr)
      pio_pkg::A_MOD0_IN:  next_prdata[9:0] = eff_in[9:0];
      pio_pkg::A_MOD0_OUT: next_prdata[5:0] = out0;
      pio_pkg::A_MOD1_IN:  next_prdata[9:0] = eff_in[19:10];
      pio_pkg::A_MOD1_OUT: next_prdata[5:0] = out1;
      pio_pkg::A_INT_SEL:  next_prdata[7:0] = int_sel;
      pio_pkg::A_QRS_SEL:  next_prdata[7:0] = qrs_sel;
      pio_pkg::A_CNT_SEL:  next_prdata[7:0] = cnt_sel;
      pio_pkg::A_ORG_SEL:  next_prdata[5:0] = org_sel;
      pio_pkg::A_TC_SEL: begin
        next_prdata[2:0] = tc_pend;
        next_prdata[pio_pkg::TC_ACT_LSB +: 3] = tc_act;
      end
      pio_pkg::A_INSTR:    next_prdata = 32'h00000000;
      pio_pkg::A_STATUS: begin
        next_prdata[19:0] = conflict;
        next_prdata[pio_pkg::REFUSED_BIT] = refused_q;
      end
      default:             mapped = 1'h0;
    endcase
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      prdata <= 32'h00000000;
    else if (setup)
      prdata <= next_prdata;
  end

  // Configuration registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out0    <= 6'h00;
      out1    <= 6'h00;
      int_sel <= 8'h00;
      qrs_sel <= 8'h00;
      cnt_sel <= 8'h00;
      org_sel <= 6'h00;
      tc_pend <= pio_pkg::TC_DEFAULT;
    end else if (wr) begin
      unique case (paddr)
        pio_pkg::A_MOD0_OUT: out0    <= pwdata[5:0];
        pio_pkg::A_MOD1_OUT: out1    <= pwdata[5:0];
        pio_pkg::A_INT_SEL:  int_sel <= pwdata[7:0];
        pio_pkg::A_QRS_SEL:  qrs_sel <= pwdata[7:0];
        pio_pkg::A_CNT_SEL:  cnt_sel <= pwdata[7:0];
        pio_pkg::A_ORG_SEL:  org_sel <= pwdata[5:0];
        pio_pkg::A_TC_SEL:   tc_pend <= pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Running filter keeps its setting until the next power-on load
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      tc_act <= pio_pkg::TC_DEFAULT;
    else if (ce && power_on_load)
      tc_act <= tc_pend;
  end

  // Refused PWM flag: write one to clear, a new refusal wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      refused_q <= 1'h0;
    else if (|refused)
      refused_q <= 1'h1;
    else if (wr && paddr == pio_pkg::A_STATUS && pwdata[pio_pkg::REFUSED_BIT])
      refused_q <= 1'h0;
  end

  // Claims per terminal, one module at a time
  for (genvar m = 0; m < 2; m++) begin : g_mod
    localparam int T = 10 * m;
    localparam int A = 2 * m;
    localparam int B = 2 * m + 1;
    assign o_c[T +: 10] = {4'h0, org_sel[B], org_sel[A], org_sel[B],
                           org_sel[B], org_sel[A], org_sel[A]};
    assign c_c[T +: 10] = {cnt_sel[A], cnt_sel[A], cnt_sel[B], cnt_sel[B], 2'h0,
                           cnt_sel[A] & cnt_sel[pio_pkg::ZUSE_LSB + A],
                           cnt_sel[B] & cnt_sel[pio_pkg::ZUSE_LSB + B], 2'h0};
    assign i_c[T +: 10] = {6'h00, int_sel[4 * m +: 4]};
    assign q_c[T +: 10] = {6'h00, qrs_sel[4 * m +: 4]};
    // Special functions read the raw pin, never the filter
    assign next_intr[4 * m +: 4] = term_in[T +: 4] & i_g[T +: 4];
    assign next_qrs[4 * m +: 4]  = term_in[T +: 4] & q_g[T +: 4];
    assign next_cnt_z[B] = term_in[T + 2] & c_g[T + 2];
    assign next_cnt_z[A] = term_in[T + 3] & c_g[T + 3];
    assign next_cnt_a[B] = term_in[T + 6] & c_g[T + 6];
    assign next_cnt_b[B] = term_in[T + 7] & c_g[T + 7];
    assign next_cnt_a[A] = term_in[T + 8] & c_g[T + 8];
    assign next_cnt_b[A] = term_in[T + 9] & c_g[T + 9];
    assign next_org[A]   = term_in[T] & o_g[T];
    assign next_prox[A]  = term_in[T + 1] & o_g[T + 1];
    assign next_org[B]   = term_in[T + 2] & o_g[T + 2];
    assign next_prox[B]  = term_in[T + 3] & o_g[T + 3];
    assign next_done[A]  = term_in[T + 4] & o_g[T + 4];
    assign next_done[B]  = term_in[T + 5] & o_g[T + 5];
  end

  // Misconfiguration is resolved by a fixed order, and still reported
  assign o_g = o_c;
  assign c_g = c_c & ~o_c;
  assign i_g = i_c & ~o_c & ~c_c;
  assign q_g = q_c & ~o_c & ~c_c & ~i_c;
  assign n_g = ~(o_c | c_c | i_c | q_c);
  assign conflict = (o_c & (c_c | i_c | q_c)) | (c_c & (i_c | q_c)) | (i_c & q_c);
  assign eff_in = (filt & n_g) | (term_in & ~n_g);

  // Routed functions, one flop stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      norm_in  <= 20'h00000;
      intr_in  <= 8'h00;
      qrs_in   <= 8'h00;
      cnt_a    <= 4'h0;
      cnt_b    <= 4'h0;
      cnt_z    <= 4'h0;
      org_in   <= 4'h0;
      org_prox <= 4'h0;
      pos_done <= 4'h0;
    end else if (ce) begin
      norm_in  <= filt & n_g;
      intr_in  <= next_intr;
      qrs_in   <= next_qrs;
      cnt_a    <= next_cnt_a;
      cnt_b    <= next_cnt_b;
      cnt_z    <= next_cnt_z;
      org_in   <= next_org;
      org_prox <= next_prox;
      pos_done <= next_done;
    end
  end

  pio_in_filter #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_filter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .raw     (term_in),
    .tc_code (tc_act),
    .filt    (filt)
  );

  for (genvar m = 0; m < 2; m++) begin : g_out
    pio_out_bind u_bind (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .cmd_valid (instr_wr && pwdata[pio_pkg::I_MOD_BIT] == 1'(m)),
      .cmd_op    (pwdata[1:0]),
      .cmd_ch    (pwdata[pio_pkg::I_CH_BIT]),
      .cmd_meth  (pwdata[pio_pkg::I_METH_BIT]),
      .cmd_bit   (pwdata[pio_pkg::I_BIT_LSB +: 3]),
      .org_mode  (org_sel[pio_pkg::OMODE_LSB +: 2]),
      .refused   (refused[m]),
      .norm_out  (m == 0 ? out0 : out1),
      .pulse_a   (pulse_a[2 * m +: 2]),
      .pulse_b   (pulse_b[2 * m +: 2]),
      .ecr       (ecr[2 * m +: 2]),
      .pwm       (pwm[2 * m +: 2]),
      .term_out  (term_out[6 * m +: 6])
    );
  end
endmodule // pio_terminal_allocator

/* File: sim/pio_ta_assertions.sv */
/*
  Port checker for the terminal allocator.
  Assumes one clock domain; bound in at the foot of this file.
*/
`timescale 1ns/1ps
module pio_ta_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        ce,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Terminals
  input wire logic [19:0] term_in,
  input wire logic [19:0] norm_in,
  input wire logic [7:0]  intr_in,
  input wire logic [7:0]  qrs_in,
  input wire logic [3:0]  cnt_a
);
  logic [19:0] tin_q;
  logic [7:0]  qrs_q;
  logic        ce_q;
  logic        hi;
  logic        al;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  assign hi = paddr > 8'h28;
  assign al = paddr[1:0] == 2'h0;

  // Raw views are registered once, so compare against last edge's pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tin_q <= '0;
      qrs_q <= '0;
      ce_q <= 1'b0;
    end else begin
      tin_q <= term_in;
      qrs_q <= qrs_in;
      ce_q <= ce;
    end
  end

  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_access;
    psel && penable && ce;
  endsequence

  chk_ready_ce: assert property (pready == ce)
    else $error("pready differs from ce");
  chk_err_unmapped: assert property (s_access ##0 (hi && al) |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (psel && penable && !hi && al |-> !pslverr)
    else $error("error on mapped access");
  chk_err_setup: assert property (!penable |-> !pslverr)
    else $error("error outside access phase");
  chk_xfer_done: assert property (s_setup ##1 s_access |-> pready)
    else $error("access not completed");
  chk_read_zero: assert property (s_setup ##0 (hi && al) |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_prdata_hold: assert property (!(psel && !penable && ce) |=> $stable(prdata))
    else $error("read data moved outside setup");
  chk_qrs_raw: assert property (
    ce_q |-> (qrs_in & ~{tin_q[13:10], tin_q[3:0]}) == 8'h00)
    else $error("quick input not raw");
  chk_cnt_raw: assert property (
    ce_q |-> (cnt_a & ~{tin_q[16], tin_q[18], tin_q[6], tin_q[8]}) == 4'h0)
    else $error("counter input not raw");
  chk_qrs_excl: assert property (
    (qrs_in & qrs_q & {norm_in[13:10], norm_in[3:0]}) == 8'h00)
    else $error("quick terminal also normal");
  chk_one_func: assert property ((qrs_in & intr_in) == 8'h00)
    else $error("terminal with two functions");
endmodule // pio_ta_assertions

bind pio_terminal_allocator pio_ta_assertions i_chk (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .term_in(term_in), .norm_in(norm_in), .intr_in(intr_in), .qrs_in(qrs_in),
  .cnt_a(cnt_a)
);

/* File: sim/pio_field_model.sv */
/*
  Field contacts: levels from the bench reach the terminals with bounce.
  Assumes the bench changes levels at clock edges.
*/
`timescale 1ns/1ps
module pio_field_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Contact levels and terminal pins
  input  wire logic [19:0] lvl,
  output logic      [19:0] term_in
);
  logic [19:0] last;
  logic [19:0] chg;
  logic [2:0]  cnt;

  // Real switches chatter, so a changed contact toggles before it settles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last <= '0;
      chg <= '0;
      cnt <= '0;
      term_in <= '0;
    end else if (lvl != last) begin
      last <= lvl;
      chg <= lvl ^ last;
      cnt <= 3'h5;
      term_in <= term_in ^ lvl ^ last;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      term_in <= (cnt == 3'h1) ? lvl : term_in ^ chg;
    end
  end
endmodule // pio_field_model

/* File: sim/pio_terminal_allocator_tb.sv */
/*
  Self-checking bench for the terminal allocator with a binding model.
  Assumes the checker and field model are compiled before it.
*/
`timescale 1ns/1ps
module pio_terminal_allocator_tb;
  logic        clk, sys_rst, ce, power_on_load, psel, penable, pwrite, err;
  logic [7:0]  paddr, intr_in, qrs_in;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr;
  logic [19:0] lvl, term_in, norm_in;
  logic [3:0]  cnt_a, org_in, pa, pb, ecr, pwm;
  logic [11:0] term_out, mo;
  int          n_mismatch, tests_run, mode, refused, r;
  int          fn[12], chn[12];
  int          q[$];

  pio_terminal_allocator #(.TICK_CYCLES(4)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .power_on_load(power_on_load),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_in(term_in), .norm_in(norm_in), .intr_in(intr_in), .qrs_in(qrs_in),
    .cnt_a(cnt_a), .cnt_b(), .cnt_z(), .org_in(org_in), .org_prox(),
    .pos_done(), .pulse_a(pa), .pulse_b(pb), .ecr(ecr), .pwm(pwm),
    .term_out(term_out)
  );
  pio_field_model i_field (.clk(clk), .sys_rst(sys_rst), .lvl(lvl), .term_in(term_in));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The master never assumes a latency; only the count bounds the wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A slave that never answers ends the run through the verdict
    if (pready !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic bindt(input int t, input int f, input int c);
    fn[t] = f;
    chn[t] = c;
  endtask

  // Function codes: 0 normal, 1 pulse/CW, 2 COUNTER_CLOCKWISE_PULSE/direction, 3 error reset, 4 PWM
  task automatic apply(input int w);
    int op, m, c, s, b;
    op = w & 3;
    m = 6 * ((w >> 2) & 1);
    c = (w >> 3) & 1;
    s = (w >> 4) & 1;
    b = (w >> 8) & 7;
    if (op == 0 && b < 6) fn[m + b] = 0;
    if (op == 1 || op == 2) begin
      bindt(m + (s ? c : 2 * c), 1, m / 3 + c);
      bindt(m + (s ? c + 2 : 2 * c + 1), 2, m / 3 + c);
    end
    if (op == 2 && mode != 0) bindt(m + 4 + c, 3, m / 3 + c);
    if (op == 3 && mode != 0) refused = 1;
    else if (op == 3) bindt(m + 4 + c, 4, m / 3 + c);
  endtask

  function automatic logic [11:0] exp_out();
    logic [11:0] e;
    for (int t = 0; t < 12; t++)
      case (fn[t])
        0: e[t] = mo[t];
        1: e[t] = pa[chn[t]];
        2: e[t] = pb[chn[t]];
        3: e[t] = ecr[chn[t]];
        default: e[t] = pwm[chn[t]];
      endcase
    return e;
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    {power_on_load, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lvl = 20'h0;
    {pa, pb, ecr, pwm} = 16'h0;
    mode = 0;
    refused = 0;
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(63204));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, pio_pkg::A_TC_SEL, 32'h0);
    chk("tc_sel", 32'h505, rd);
    apb(1'b1, 8'h40, 32'hffffffff);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    @(posedge clk);
    ce <= 1'b0;
    settle(2);
    chk("pready", 32'h0, {31'h0, pready});
    @(posedge clk);
    ce <= 1'b1;
    $display("reset and bus test done");

    apb(1'b1, pio_pkg::A_QRS_SEL, 32'h4);
    apb(1'b1, pio_pkg::A_CNT_SEL, 32'h2);
    r = $urandom;
    @(posedge clk);
    lvl <= {r[9:0], 10'h064};
    settle(10);
    chk("qrs_in", 32'h4, {24'h0, qrs_in});
    chk("cnt_a", 32'h2, {28'h0, cnt_a});
    chk("norm_slow", 32'h0, {12'h0, norm_in});
    settle(90);
    chk("norm_in", {12'h0, r[9:0], 10'h020}, {12'h0, norm_in});
    chk("intr_in", 32'h0, {24'h0, intr_in});
    apb(1'b0, pio_pkg::A_MOD0_IN, 32'h0);
    chk("mod0_in", 32'h64, rd);
    apb(1'b1, pio_pkg::A_ORG_SEL, 32'h2);
    settle(2);
    chk("org_in", 32'h2, {28'h0, org_in});
    chk("qrs_lost", 32'h0, {24'h0, qrs_in});
    apb(1'b0, pio_pkg::A_STATUS, 32'h0);
    chk("conflict", 32'h4, rd);
    apb(1'b1, pio_pkg::A_ORG_SEL, 32'h0);
    apb(1'b1, pio_pkg::A_TC_SEL, 32'h1);
    apb(1'b0, pio_pkg::A_TC_SEL, 32'h0);
    chk("tc_pending", 32'h501, rd);
    @(posedge clk);
    power_on_load <= 1'b1;
    @(posedge clk);
    power_on_load <= 1'b0;
    apb(1'b0, pio_pkg::A_TC_SEL, 32'h0);
    chk("tc_active", 32'h101, rd);
    @(posedge clk);
    lvl <= 20'h0;
    settle(20);
    chk("norm_fast", 32'h0, {12'h0, norm_in});
    $display("input test done");

    mo = 12'($urandom);
    apb(1'b1, pio_pkg::A_MOD0_OUT, {26'h0, mo[5:0]});
    apb(1'b1, pio_pkg::A_MOD1_OUT, {26'h0, mo[11:6]});
    settle(2);
    chk("term_out", {20'h0, mo}, {20'h0, term_out});
    // A negative entry switches the origin search to mode one
    q = '{'h300, 'h1, 'h1d, 'hb, 'h6, 'h704, 'h4, 'h500, -1, 'h3, 'h12, 'hf};
    foreach (q[i]) begin
      if (q[i] < 0) begin
        mode = 1;
        apb(1'b1, pio_pkg::A_ORG_SEL, 32'h10);
      end else begin
        apply(q[i]);
        apb(1'b1, pio_pkg::A_INSTR, 32'(q[i]));
      end
      @(posedge clk);
      {pa, pb, ecr, pwm} <= 16'($urandom);
      settle(2);
      chk("term_out", {20'h0, exp_out()}, {20'h0, term_out});
    end
    apb(1'b0, pio_pkg::A_STATUS, 32'h0);
    chk("refused", 32'(refused), {31'h0, rd[pio_pkg::REFUSED_BIT]});
    apb(1'b1, pio_pkg::A_STATUS, 32'h100000);
    apb(1'b0, pio_pkg::A_STATUS, 32'h0);
    chk("refused_clr", 32'h0, {31'h0, rd[pio_pkg::REFUSED_BIT]});
    $display("output binding test done");
    summarize();
  end
endmodule // pio_terminal_allocator_tb
